// file: hw/sep_pkg.sv
// shared constants and types of the serial eeprom command port
// assumes a 100 MHz system clock that samples every pin of the link
package sep_pkg;

    localparam int CLK_MHZ = 100;

    // self-timed cycle limits, in microseconds
    localparam int WORD_TIME_US = 5000;
    localparam int BULK_ERASE_TIME_US = 6000;
    localparam int BULK_WRITE_TIME_US = 15000;
    localparam int WORD_CYC = WORD_TIME_US * CLK_MHZ;
    localparam int BULK_ERASE_CYC = BULK_ERASE_TIME_US * CLK_MHZ;
    localparam int BULK_WRITE_CYC = BULK_WRITE_TIME_US * CLK_MHZ;
    localparam int TMR_W = 21;

    // least select-low time before status is shown
    localparam int CS_LOW_TIME_NS = 250;
    localparam logic [4:0] CS_LOW_CYC =
        5'((CS_LOW_TIME_NS * CLK_MHZ + 999) / 1000);

    // bit counts after the start bit at which fields complete, and bits per output word
    localparam logic [4:0] OPC_END = 5'h02;
    localparam logic [4:0] SUB_END = 5'h04;
    localparam logic [4:0] ADDR_END_WIDE = 5'h0C;
    localparam logic [4:0] ADDR_END_NARROW = 5'h0D;
    localparam logic [4:0] DATA_END_WIDE = 5'h1C;
    localparam logic [4:0] DATA_END_NARROW = 5'h15;
    localparam logic [4:0] BITS_WIDE = 5'h10;
    localparam logic [4:0] BITS_NARROW = 5'h08;

    localparam int ARRAY_WORDS = 1024;
    localparam logic [9:0] LAST_WORD = 10'h3FF;
    localparam logic [15:0] ERASED = 16'hFFFF;
    localparam logic WR_EN_RST = 1'b0;

    localparam logic [1:0] OPC_EXT = 2'h0;
    localparam logic [1:0] OPC_WRITE = 2'h1;
    localparam logic [1:0] OPC_READ = 2'h2;
    localparam logic [1:0] OPC_ERASE = 2'h3;
    localparam logic [1:0] SUB_WDS = 2'h0;
    localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
    localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
    localparam logic [1:0] SUB_WEN = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CMD = 2'h1,
        ST_READ = 2'h2,
        ST_DONE = 2'h3
    } sep_state_t;

    typedef enum logic [1:0] {
        PG_WORD = 2'h0,
        PG_ERASE_ALL = 2'h1,
        PG_WRITE_ALL = 2'h2
    } sep_prog_t;

endpackage

// file: hw/sep_sync.sv
// two-flop synchronisers, one per bit
// assumes each input bit is an independent level from outside the domain
`timescale 1ns/1ps
module sep_sync #(
    parameter int WIDTH = 5
)(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    for (genvar g = 0; g < WIDTH; g++)
    begin : g_bit
        logic s1;
        logic s2;
        always_ff @(posedge i_clk or negedge i_resetn)
        begin
            if (!i_resetn)
            begin
                s1 <= 1'b0;
                s2 <= 1'b0;
            end
            else
            begin
                s1 <= i_async[g];
                s2 <= s1;
            end
        end
        assign o_sync[g] = s2;
    end

endmodule // sep_sync

// file: hw/sep_buf.sv
// small valid/ready buffer between array fetch and output shifter
// assumes nothing of flush timing; a flush cancels any push or pop in the same cycle
`timescale 1ns/1ps
module sep_buf #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
)(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_flush,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PLAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
    logic push;
    logic pop;

    assign o_ready = (count != CW'(DEPTH));
    assign o_valid = (count != '0);
    assign o_data = mem[rptr];
    assign push = i_valid && o_ready && !i_flush;
    assign pop = o_valid && i_ready && !i_flush;

    always_ff @(posedge i_clk)
    begin
        if (push)
            mem[wptr] <= i_data;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end
        else if (i_flush)
        begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wptr <= (wptr == PLAST) ? '0 : wptr + PW'(1);
            if (pop)
                rptr <= (rptr == PLAST) ? '0 : rptr + PW'(1);
            count <= count + CW'(push) - CW'(pop);
        end
    end

endmodule // sep_buf

// file: hw/sep_port.sv
// command front end of a 16-kbit three-wire serial eeprom, with its array
// assumes select, serial clock and data in come from an outside master
// and are sampled here by the 100 MHz system clock
`timescale 1ns/1ps
module sep_port #(
    parameter int P_WORD_CYC = sep_pkg::WORD_CYC,
    parameter int P_ERASE_ALL_CYC = sep_pkg::BULK_ERASE_CYC,
    parameter int P_WRITE_ALL_CYC = sep_pkg::BULK_WRITE_CYC
)(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_chip_select,
    input wire logic i_serial_clk,
    input wire logic i_data_in,
    input wire logic i_word_width_select,
    input wire logic i_program_permit_input,
    output logic o_data_out,
    output logic o_data_out_oe_n,
    output logic o_busy,
    output logic o_write_enabled
);

    localparam int TW = sep_pkg::TMR_W;

    logic [4:0] pins_s;
    logic sel_s;
    logic sclk_s;
    logic din_s;
    logic wide_s;
    logic permit_s;
    logic sclk_d;
    logic sel_d;
    logic sclk_rise;

    sep_pkg::sep_state_t state;
    logic [4:0] cnt;
    logic [15:0] cmd;
    logic [1:0] opc;
    logic [1:0] sub;
    logic wide_q;
    logic [10:0] addr_q;
    logic [15:0] next_cmd;
    logic [4:0] next_cnt;
    logic [4:0] addr_end;
    logic [4:0] data_end;
    logic [10:0] addr_now;
    logic [10:0] addr_sel;
    logic need_data;
    logic last_bit;
    logic start_seen;

    logic exec;
    logic exec_read;
    logic exec_erase;
    logic exec_write;
    logic exec_ext;
    logic exec_wen;
    logic exec_wds;
    logic exec_erase_all;
    logic exec_write_all;
    logic prog_req;
    logic prog_start;
    logic wr_en;

    logic busy;
    sep_pkg::sep_prog_t pkind;
    logic [TW-1:0] tmr;
    logic [9:0] sweep;
    logic sweeping;
    logic [15:0] fill;
    logic [15:0] wdata;
    logic [15:0] w_val;
    logic [15:0] w_mask;
    logic [9:0] widx;
    logic [15:0] mem [sep_pkg::ARRAY_WORDS];

    logic fetching;
    logic [10:0] rd_ptr;
    logic [15:0] rd_word;
    logic [15:0] fetch_data;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [15:0] buf_data;
    logic buf_flush;
    logic pop;
    logic [15:0] load;
    logic [15:0] sh;
    logic [4:0] sh_left;
    logic dout_bit;

    logic armed;
    logic show;
    logic saw_start;
    logic [4:0] low_cnt;

    assign {sel_s, sclk_s, din_s, wide_s, permit_s} = pins_s;

    sep_sync #(.WIDTH(5)) u_sync (
        .i_clk(i_clk_sys),
        .i_resetn(i_resetn),
        .i_async({i_chip_select, i_serial_clk, i_data_in,
                  i_word_width_select, i_program_permit_input}),
        .o_sync(pins_s)
    );

    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            sclk_d <= 1'b0;
            sel_d <= 1'b0;
        end
        else
        begin
            sclk_d <= sclk_s;
            sel_d <= sel_s;
        end
    end

    assign sclk_rise = sclk_s && !sclk_d;

    // command decode; fields arrive msb first
    assign next_cmd = {cmd[14:0], din_s};
    assign next_cnt = cnt + 5'h01;
    assign addr_end = wide_q ? sep_pkg::ADDR_END_WIDE
                             : sep_pkg::ADDR_END_NARROW;
    assign data_end = wide_q ? sep_pkg::DATA_END_WIDE
                             : sep_pkg::DATA_END_NARROW;
    assign addr_now = wide_q ? {1'b0, next_cmd[9:0]} : next_cmd[10:0];
    assign addr_sel = (next_cnt == addr_end) ? addr_now : addr_q;
    assign need_data = (opc == sep_pkg::OPC_WRITE) ||
        (opc == sep_pkg::OPC_EXT && sub == sep_pkg::SUB_WRITE_ALL);
    assign last_bit = need_data ? (next_cnt == data_end)
                                : (next_cnt == addr_end);
    assign start_seen = (state == sep_pkg::ST_IDLE) && sclk_rise &&
                        sel_s && din_s;

    // a busy array ignores every instruction
    assign exec = (state == sep_pkg::ST_CMD) && sclk_rise && sel_s &&
                  last_bit && !busy;
    assign exec_read = exec && opc == sep_pkg::OPC_READ;
    assign exec_erase = exec && opc == sep_pkg::OPC_ERASE;
    assign exec_write = exec && opc == sep_pkg::OPC_WRITE;
    assign exec_ext = exec && opc == sep_pkg::OPC_EXT;
    assign exec_wen = exec_ext && sub == sep_pkg::SUB_WEN;
    assign exec_wds = exec_ext && sub == sep_pkg::SUB_WDS;
    assign exec_erase_all = exec_ext && sub == sep_pkg::SUB_ERASE_ALL;
    assign exec_write_all = exec_ext && sub == sep_pkg::SUB_WRITE_ALL;
    assign prog_req = exec_erase || exec_write ||
                      exec_erase_all || exec_write_all;
    assign prog_start = prog_req && wr_en && permit_s;

    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state <= sep_pkg::ST_IDLE;
            cnt <= 5'h00;
            cmd <= 16'h0000;
            opc <= 2'h0;
            sub <= 2'h0;
            wide_q <= 1'b0;
            addr_q <= 11'h000;
        end
        else if (!sel_s)
            state <= sep_pkg::ST_IDLE;
        else if (sclk_rise)
        begin
            case (state)
                sep_pkg::ST_IDLE:
                begin
                    if (din_s)
                    begin
                        state <= sep_pkg::ST_CMD;
                        cnt <= 5'h00;
                        wide_q <= wide_s;
                    end
                end
                sep_pkg::ST_CMD:
                begin
                    cmd <= next_cmd;
                    cnt <= next_cnt;
                    if (next_cnt == sep_pkg::OPC_END)
                        opc <= next_cmd[1:0];
                    if (next_cnt == sep_pkg::SUB_END)
                        sub <= next_cmd[1:0];
                    if (next_cnt == addr_end)
                        addr_q <= addr_now;
                    if (last_bit)
                        state <= exec_read ? sep_pkg::ST_READ
                                           : sep_pkg::ST_DONE;
                end
                sep_pkg::ST_READ:
                    state <= sep_pkg::ST_READ;
                sep_pkg::ST_DONE:
                    state <= sep_pkg::ST_DONE;
                default:
                    state <= sep_pkg::ST_IDLE;
            endcase
        end
    end

    // enable flag survives select and stays until changed
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
            wr_en <= sep_pkg::WR_EN_RST;
        else if (exec_wen)
            wr_en <= 1'b1;
        else if (exec_wds)
            wr_en <= 1'b0;
    end

    // write values: narrow bytes sit high for even, low for odd addresses
    assign wdata = wide_q ? next_cmd : {next_cmd[7:0], next_cmd[7:0]};
    assign w_val = exec_erase ? sep_pkg::ERASED : wdata;
    assign w_mask = wide_q ? 16'hFFFF
                           : (addr_sel[0] ? 16'h00FF : 16'hFF00);
    assign widx = wide_q ? addr_sel[9:0] : addr_sel[10:1];

    // self-timed cycle; runs on regardless of select
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            busy <= 1'b0;
            pkind <= sep_pkg::PG_WORD;
            tmr <= '0;
            sweep <= 10'h000;
            sweeping <= 1'b0;
            fill <= 16'h0000;
        end
        else if (prog_start)
        begin
            busy <= 1'b1;
            sweep <= 10'h000;
            sweeping <= exec_erase_all || exec_write_all;
            fill <= exec_write_all ? wdata : sep_pkg::ERASED;
            if (exec_erase_all)
            begin
                pkind <= sep_pkg::PG_ERASE_ALL;
                tmr <= TW'(P_ERASE_ALL_CYC - 1);
            end
            else if (exec_write_all)
            begin
                pkind <= sep_pkg::PG_WRITE_ALL;
                tmr <= TW'(P_WRITE_ALL_CYC - 1);
            end
            else
            begin
                pkind <= sep_pkg::PG_WORD;
                tmr <= TW'(P_WORD_CYC - 1);
            end
        end
        else if (busy)
        begin
            if (tmr == '0)
                busy <= 1'b0;
            else
                tmr <= tmr - TW'(1);
            if (sweeping)
            begin
                sweep <= sweep + 10'h001;
                if (sweep == sep_pkg::LAST_WORD)
                    sweeping <= 1'b0;
            end
        end
    end

    // the array; bulk cycles overwrite one word per clock
    always_ff @(posedge i_clk_sys)
    begin
        if (prog_start && (exec_erase || exec_write))
            mem[widx] <= (mem[widx] & ~w_mask) | (w_val & w_mask);
        else if (sweeping)
            mem[sweep] <= fill;
    end

    // prefetch of read words, stalled by the buffer
    assign rd_word = mem[wide_q ? rd_ptr[9:0] : rd_ptr[10:1]];
    assign fetch_data = wide_q ? rd_word :
        {8'h00, (rd_ptr[0] ? rd_word[7:0] : rd_word[15:8])};
    assign buf_flush = !sel_s || exec_read;

    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            fetching <= 1'b0;
            rd_ptr <= 11'h000;
        end
        else if (!sel_s)
            fetching <= 1'b0;
        else if (exec_read)
        begin
            fetching <= 1'b1;
            rd_ptr <= addr_now;
        end
        else if (fetching && buf_in_ready)
        begin
            // wide mode wraps inside its 10-bit word space
            rd_ptr <= (rd_ptr + 11'h001) & (wide_q ? 11'h3FF : 11'h7FF);
        end
    end

    sep_buf #(.WIDTH(16), .DEPTH(2)) u_buf (
        .i_clk(i_clk_sys),
        .i_resetn(i_resetn),
        .i_flush(buf_flush),
        .i_valid(fetching),
        .o_ready(buf_in_ready),
        .i_data(fetch_data),
        .o_valid(buf_out_valid),
        .i_ready(pop),
        .o_data(buf_data)
    );

    // output shifter: dummy zero, then words msb first while clocked
    assign pop = (state == sep_pkg::ST_READ) && sel_s && sclk_rise &&
                 (sh_left == 5'h00) && buf_out_valid;
    assign load = wide_q ? buf_data : {buf_data[7:0], 8'h00};

    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            sh <= 16'h0000;
            sh_left <= 5'h00;
            dout_bit <= 1'b0;
        end
        else if (exec_read)
        begin
            dout_bit <= 1'b0;
            sh_left <= 5'h00;
        end
        else if (pop)
        begin
            dout_bit <= load[15];
            sh <= {load[14:0], 1'b0};
            sh_left <= (wide_q ? sep_pkg::BITS_WIDE
                               : sep_pkg::BITS_NARROW) - 5'h01;
        end
        else if ((state == sep_pkg::ST_READ) && sclk_rise &&
                 (sh_left != 5'h00))
        begin
            dout_bit <= sh[15];
            sh <= {sh[14:0], 1'b0};
            sh_left <= sh_left - 5'h01;
        end
    end

    // status: after a programming start, a long enough low, then select high, shows ready/busy
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            armed <= 1'b0;
            show <= 1'b0;
            saw_start <= 1'b0;
            low_cnt <= 5'h00;
        end
        else
        begin
            if (!sel_s && low_cnt != sep_pkg::CS_LOW_CYC)
                low_cnt <= low_cnt + 5'h01;
            else if (sel_s)
                low_cnt <= 5'h00;
            if (start_seen)
                saw_start <= 1'b1;
            else if (!sel_s)
                saw_start <= 1'b0;
            if (sel_s && !sel_d && armed &&
                low_cnt == sep_pkg::CS_LOW_CYC)
                show <= 1'b1;
            else if (!sel_s)
                show <= 1'b0;
            if (prog_start)
                armed <= 1'b1;
            else if (!sel_s && sel_d && saw_start && !busy)
                armed <= 1'b0;
        end
    end

    // a read frame takes the pin; status otherwise; float by default
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_data_out <= 1'b0;
            o_data_out_oe_n <= 1'b1;
        end
        else if (!sel_s)
            o_data_out_oe_n <= 1'b1;
        else if (state == sep_pkg::ST_READ)
        begin
            o_data_out_oe_n <= 1'b0;
            o_data_out <= dout_bit;
        end
        else if (show)
        begin
            o_data_out_oe_n <= 1'b0;
            o_data_out <= !busy;
        end
        else
            o_data_out_oe_n <= 1'b1;
    end

    assign o_busy = busy;
    assign o_write_enabled = wr_en;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    property p_release;
        !sel_s |=> o_data_out_oe_n;
    endproperty
    a_release: assert property (p_release)
        else $error("data out driven with select low");

    property p_drive_cause;
        !o_data_out_oe_n |-> $past(state == sep_pkg::ST_READ || show);
    endproperty
    a_drive_cause: assert property (p_drive_cause)
        else $error("data out driven outside read or status");

    property p_status;
        (sel_s && show && state != sep_pkg::ST_READ) |=>
            (!o_data_out_oe_n && o_data_out == !$past(busy));
    endproperty
    a_status: assert property (p_status)
        else $error("status level wrong");

    property p_dummy;
        exec_read ##1 sel_s |=> (!o_data_out_oe_n && !o_data_out);
    endproperty
    a_dummy: assert property (p_dummy)
        else $error("no leading zero before read data");

    // check the effect too, not only the decode terms
    property p_idle_quiet;
        (state == sep_pkg::ST_IDLE) |-> !exec && !prog_start
            ##1 $stable(wr_en) && !$rose(busy);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("operation without start bit");

    property p_start;
        start_seen |=> state == sep_pkg::ST_CMD && cnt == 5'h00;
    endproperty
    a_start: assert property (p_start)
        else $error("start bit not taken");

    property p_cs_reset;
        !sel_s |=> state == sep_pkg::ST_IDLE;
    endproperty
    a_cs_reset: assert property (p_cs_reset)
        else $error("control not reset by select low");

    property p_protect;
        prog_req && (!wr_en || !permit_s) |=> !busy && !sweeping;
    endproperty
    a_protect: assert property (p_protect)
        else $error("programming started while protected");

    property p_flag;
        exec_wen |=> wr_en ##1 (wr_en || $past(exec_wds));
    endproperty
    a_flag: assert property (p_flag)
        else $error("enable flag not held");

    property p_busy_min;
        $rose(busy) |-> busy [*8];
    endproperty
    a_busy_min: assert property (p_busy_min)
        else $error("self-timed cycle too short");

    property p_busy_end;
        busy && tmr == '0 && !prog_start |=> !busy;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("self-timed cycle overran");

    // a bulk cycle must have swept every word before it reports ready
    property p_bulk_sweep;
        (busy && pkind != sep_pkg::PG_WORD && tmr == '0) |-> !sweeping;
    endproperty
    a_bulk_sweep: assert property (p_bulk_sweep)
        else $error("bulk cycle ended before the whole array was written");

    c_read: cover property (exec_read ##[1:1000] pop);
    c_write_all: cover property (prog_start && exec_write_all);
    c_status_ready: cover property (show && !busy && sel_s);

endmodule // sep_port

// file: sim/sep_master.sv
// serial master model: drives select, serial clock and data in
// assumes the bench system clock paces it; serial clock idles low
`timescale 1ns/1ps
module sep_master (
    input wire logic i_clk,
    input wire logic i_do,
    output logic o_cs,
    output logic o_sclk,
    output logic o_di
);
    initial
    begin
        o_cs = 1'b0;
        o_sclk = 1'b0;
        o_di = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic sel(input logic v);
        o_cs = v;
        tick(30);
    endtask
    // n rises, msb first; rx holds data out as seen just before each rise
    task automatic xfer(input int n, input logic [63:0] v,
                        output logic [31:0] rx);
        o_cs = 1'b1;
        for (int i = n - 1; i >= 0; i--)
        begin
            o_di = v[i];
            tick(4);
            rx = {rx[30:0], i_do};
            o_sclk = 1'b1;
            tick(4);
            o_sclk = 1'b0;
        end
        // released line shows the inverse so a stale level cannot pass
        o_di = ~o_di;
        o_cs = 1'b0;
        tick(30);
    endtask
endmodule // sep_master

// file: sim/sep_port_tb_top.sv
// self-checking bench for the serial eeprom command port
// assumes the master model in sep_master.sv and shortened cycle times
`timescale 1ns/1ps
module sep_port_tb_top;
    logic clk = 1'b0;
    logic resetn;
    logic wws;
    logic permit;
    logic do_line;
    logic cs, sclk, di, dout, oe_n, busy, wen;
    // a floating data out shows the inverse so a stale level cannot pass
    assign do_line = oe_n ? ~dout : dout;
    logic [31:0] rx;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    initial
    begin
        forever #5 clk = ~clk;
    end
    sep_master u_sep_master (.i_clk(clk), .i_do(do_line), .o_cs(cs),
        .o_sclk(sclk), .o_di(di));
    sep_port #(.P_WORD_CYC(2000), .P_ERASE_ALL_CYC(3000),
        .P_WRITE_ALL_CYC(4000)) u_sep_port (.i_clk_sys(clk),
        .i_resetn(resetn), .i_chip_select(cs), .i_serial_clk(sclk),
        .i_data_in(di), .i_word_width_select(wws),
        .i_program_permit_input(permit), .o_data_out(dout),
        .o_data_out_oe_n(oe_n), .o_busy(busy), .o_write_enabled(wen));
    task automatic chk(string name, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic go(int n, logic [63:0] v);
        u_sep_master.xfer(n, v, rx);
    endtask
    task automatic idle();
        for (int i = 0; i < 5000 && busy !== 1'b0; i++)
            u_sep_master.tick(1);
        chk("busy", 0, busy);
    endtask
    task automatic rd(logic [9:0] a, logic [15:0] e);
        go(30, {3'h6, a, 17'h0});
        chk("read", {16'h0, e}, {15'h0, rx[16:0]});
        chk("oe_n", 1, oe_n);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            err_count++;
            end_sim();
        end
    end
    initial
    begin
        resetn = 1'b0;
        wws = 1'b1;
        permit = 1'b1;
        repeat (4) @(posedge clk);
        #1 resetn = 1'b1;
        u_sep_master.tick(3);
        chk("wen", 0, wen);
        chk("oe_n", 1, oe_n);
        go(29, {3'h5, 10'h005, 16'h1234});
        chk("busy", 0, busy);
        go(13, {5'h13, 8'h00});
        chk("wen", 1, wen);
        go(29, {3'h5, 10'h005, 16'hA5C3});
        chk("busy", 1, busy);
        u_sep_master.sel(1'b1);
        chk("status", 0, {oe_n, dout});
        idle();
        u_sep_master.tick(8);
        chk("status", 1, {oe_n, dout});
        go(1, 64'h1);
        chk("oe_n", 1, oe_n);
        u_sep_master.sel(1'b1);
        chk("cleared", 1, oe_n);
        rd(10'h005, 16'hA5C3);
        go(13, {3'h7, 10'h005});
        idle();
        rd(10'h005, 16'hFFFF);
        wws = 1'b0;
        go(22, {3'h5, 11'h00B, 8'h3C});
        idle();
        go(23, {3'h6, 11'h00B, 9'h0});
        chk("byte", 9'h03C, rx[8:0]);
        wws = 1'b1;
        rd(10'h005, 16'hFF3C);
        permit = 1'b0;
        go(29, {3'h5, 10'h005, 16'h1111});
        chk("busy", 0, busy);
        permit = 1'b1;
        rd(10'h005, 16'hFF3C);
        go(29, {5'h11, 8'h00, 16'h1357});
        idle();
        go(46, {3'h6, 10'h3FF, 33'h0});
        chk("stream", 32'h13571357, rx);
        go(13, {5'h12, 8'h00});
        chk("busy", 1, busy);
        idle();
        rd(10'h005, 16'hFFFF);
        go(13, {5'h10, 8'h00});
        chk("wen", 0, wen);
        end_sim();
    end
endmodule // sep_port_tb_top
